/* File: bfsg_area_class.sv */
// Classifies one flash address against the loader and halting boundaries
`timescale 1ns/1ps
`include "bfsg_defines.svh"
module bfsg_area_class (
	// Address and fuses
	input  wire logic              [15:0] addr,
	input  wire logic              [1:0]  size_fuses,
	// Classification
	output logic                          in_loader,
	output logic                          in_halting
);
	logic [15:0] ldr_base;

	// Loader start from the fuses; every choice sits above the halting base
	always_comb begin
		unique case (size_fuses)
			2'h0: ldr_base = `BFSG_LDR_BASE_0;
			2'h1: ldr_base = `BFSG_LDR_BASE_1;
			2'h2: ldr_base = `BFSG_LDR_BASE_2;
			2'h3: ldr_base = `BFSG_LDR_BASE_3;
		endcase
		in_loader  = addr >= ldr_base;
		in_halting = addr >= `BFSG_HALT_BASE;
	end
endmodule // bfsg_area_class

/* File: bfsg_cpu_model.sv */
// CPU core model issuing self-write, load and fetch requests
`timescale 1ns/1ps
module bfsg_cpu_model
	import bfsg_pkg::*;
(
	// Clock
	input  wire logic            clock,
	// Operation requests
	output bfsg_pkg::bfsg_addr_t pc,
	output bfsg_pkg::bfsg_addr_t target,
	output logic                 flash_self_write_op,
	output logic                 program_memory_load_op,
	output logic [7:0]           r0_data,
	// Instruction fetch
	output logic                 fetch_req,
	output bfsg_pkg::bfsg_addr_t fetch_addr
);
	// Quiet bus at time zero
	initial begin
		pc = 16'hf000;
		target = 16'h0000;
		flash_self_write_op = 1'b0;
		program_memory_load_op = 1'b0;
		r0_data = 8'h00;
		fetch_req = 1'b0;
		fetch_addr = 16'h0000;
	end

	// One-cycle op; qualifiers cleared, target and data inverted after so no stale value lingers
	task automatic op(input logic ld, input bfsg_addr_t p, input bfsg_addr_t t,
			input logic [7:0] r);
		@(posedge clock);
		pc <= p;
		target <= t;
		r0_data <= r;
		program_memory_load_op <= ld;
		flash_self_write_op <= !ld;
		@(posedge clock);
		program_memory_load_op <= 1'b0;
		flash_self_write_op <= 1'b0;
		target <= ~t;
		r0_data <= ~r;
		#1;
	endtask

	// Single fetch; callers stay off a busy area except to probe blocking
	task automatic fetch(input bfsg_addr_t a);
		@(posedge clock);
		fetch_req <= 1'b1;
		fetch_addr <= a;
		@(posedge clock);
		fetch_req <= 1'b0;
		fetch_addr <= ~a;
		#1;
	endtask
endmodule // bfsg_cpu_model

/* File: bfsg_defines.svh */
// Constants for the boot flash section guard
`ifndef BFSG_DEFINES_SVH
`define BFSG_DEFINES_SVH

// Address widths (word addresses)
`define BFSG_AW             16
`define BFSG_PAGE_LSB       7
// Halting area starts at a fixed word address
`define BFSG_HALT_BASE      16'he000
// Loader start per loader size fuse setting, all inside the halting area
`define BFSG_LDR_BASE_0     16'hf000
`define BFSG_LDR_BASE_1     16'hf800
`define BFSG_LDR_BASE_2     16'hfc00
`define BFSG_LDR_BASE_3     16'hfe00
// Wishbone register offsets (byte addresses)
`define BFSG_REG_CTRL       4'h0
`define BFSG_REG_LOCK       4'h4
`define BFSG_REG_STAT       4'h8
`define BFSG_REG_CFG        4'hc
// Control register field positions
`define BFSG_CTRL_EN        0
`define BFSG_CTRL_ERASE     1
`define BFSG_CTRL_WRITE     2
`define BFSG_CTRL_LOCKSET   3
`define BFSG_CTRL_REEN      4
// Lock byte field positions (0 means programmed)
`define BFSG_LK_APP_WR      0
`define BFSG_LK_APP_RD      1
`define BFSG_LK_LDR_WR      2
`define BFSG_LK_LDR_RD      3
`define BFSG_LOCK_RESET     4'hf
// Arming window for a command, in clock cycles
`define BFSG_ARM_CYCLES     3'h4
// Flash operation time in ns, and the derived cycle count at 25 ns
`define BFSG_OP_TIME_NS     4000
`define BFSG_CLK_NS         25
`define BFSG_OP_CYCLES      (`BFSG_OP_TIME_NS / `BFSG_CLK_NS)
// Highest CPU clock during concurrent programming, in kHz
`define BFSG_CONC_MAX_KHZ   2000

`endif

/* File: bfsg_guard.sv */
// Access guard and read-while-write arbiter for self-programmed flash
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "bfsg_defines.svh"
// Notes on behaviour
// - self-write from application area is ignored
// - erase or write starts only when executing from loader area
// - loader may target any page, loader area included, locks permitting
// - concurrent-area program keeps CPU running; clock must be at most 2MHz (not checked here; the bench programs it at 40 MHz)
// - halting-area program stalls the CPU throughout
// - concurrent-area reads blocked while it is programmed; fetches only, loads ignore the busy flag
// - loader area always lies inside the halting area
// - busy flag reads one while concurrent area is blocked
// - two independent lock pairs, application and loader
// - locks only get programmed by software; only chip erase or rstn resets them
// - global write lock does not affect self-write
// - global read/write lock does not affect loads or self-writes
// - application write lock refuses self-writes into application area
// - application read lock refuses loader loads of application area
// - application read lock with loader vectors masks interrupts in app
// - loader write lock refuses self-writes into loader area
// - loader read lock refuses application loads of loader area
// - loader read lock with app vectors masks interrupts in loader
// - busy flag set on concurrent-area start, cleared by re-enable or buffer load
// - enable stays high through erase or write until done
// - lock-set armed with enable writes R0 on next self-write in 4 cycles
module bfsg_guard
	import bfsg_pkg::*;
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rstn,
	// Wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [3:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// CPU operations
	input  wire bfsg_pkg::bfsg_addr_t pc,
	input  wire bfsg_pkg::bfsg_addr_t target,
	input  wire logic                 flash_self_write_op,
	input  wire logic                 program_memory_load_op,
	input  wire logic [7:0]           r0_data,
	input  wire logic                 fetch_req,
	input  wire bfsg_pkg::bfsg_addr_t fetch_addr,
	input  wire logic                 vectors_in_loader,
	// Configuration and chip erase
	input  wire logic [1:0]           loader_size_fuses,
	input  wire logic                 chip_erase,
	// Flash and core control
	output logic                      flash_erase_start,
	output logic                      flash_write_start,
	output logic                      buf_load,
	output bfsg_pkg::bfsg_addr_t      flash_page_addr,
	output logic                      load_grant,
	output logic                      load_refused,
	output logic                      fetch_block,
	output logic                      cpu_stall,
	output logic                      irq_suppress,
	output logic [3:0]                lock_bits
);
	bfsg_state_t state, next_state;
	logic [2:0]  arm_cnt, next_arm_cnt;
	logic [15:0] op_cnt, next_op_cnt;
	logic        self_write_enable, next_self_write_enable;
	logic        cmd_erase, next_cmd_erase;
	logic        cmd_write, next_cmd_write;
	logic        lock_set_command, next_lock_set_command;
	logic        concurrent_area_reenable, next_concurrent_area_reenable;
	logic        concurrent_area_busy_flag, next_busy;
	logic        op_halting, next_op_halting;
	logic [3:0]  next_lock_bits;
	logic [1:0]  fuse_q, next_fuse_q;
	logic        next_erase_start, next_write_start, next_buf_load;
	bfsg_addr_t  next_page_addr;
	logic        next_load_grant, next_load_refused;
	logic        next_fetch_block, next_stall, next_irq_suppress;
	logic [31:0] next_dat;
	logic        next_ack;
	logic        pc_ldr, pc_halt, tg_ldr, tg_halt, fe_ldr, fe_halt;
	logic        wr_refused, rd_refused, wb_wr, prog_req;
	logic        app_wr_lk, app_rd_lk, ldr_wr_lk, ldr_rd_lk;

	// Same classifier used for executing, target and fetch addresses
	bfsg_area_class u_pc_class (
		.addr       (pc),
		.size_fuses (fuse_q),
		.in_loader  (pc_ldr),
		.in_halting (pc_halt)
	);
	bfsg_area_class u_tg_class (
		.addr       (target),
		.size_fuses (fuse_q),
		.in_loader  (tg_ldr),
		.in_halting (tg_halt)
	);
	bfsg_area_class u_fe_class (
		.addr       (fetch_addr),
		.size_fuses (fuse_q),
		.in_loader  (fe_ldr),
		.in_halting (fe_halt)
	);

	// Lock decode; locks are active when the bit reads zero
	assign app_wr_lk = ~lock_bits[`BFSG_LK_APP_WR];
	assign app_rd_lk = ~lock_bits[`BFSG_LK_APP_RD];
	assign ldr_wr_lk = ~lock_bits[`BFSG_LK_LDR_WR];
	assign ldr_rd_lk = ~lock_bits[`BFSG_LK_LDR_RD];
	// Only section locks matter; global lock modes are not inputs here
	assign wr_refused = (tg_ldr ? ldr_wr_lk : app_wr_lk);
	assign rd_refused = pc_ldr ? (~tg_ldr & app_rd_lk)
	                           : (tg_ldr & ldr_rd_lk);
	// Write acts only at the edge where the master samples ack high
	assign wb_wr    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
	// Self-write counts only when issued from the loader area
	assign prog_req = flash_self_write_op & pc_ldr & (state == BFSG_ARM);

	// Next-state logic for the self-write sequencer and flags
	always_comb begin
		next_state = state;
		next_arm_cnt = arm_cnt;
		next_op_cnt = op_cnt;
		next_self_write_enable = self_write_enable;
		next_cmd_erase = cmd_erase;
		next_cmd_write = cmd_write;
		next_lock_set_command = lock_set_command;
		next_concurrent_area_reenable = concurrent_area_reenable;
		next_busy = concurrent_area_busy_flag;
		next_op_halting = op_halting;
		next_lock_bits = lock_bits;
		next_erase_start = 1'b0;
		next_write_start = 1'b0;
		next_buf_load = 1'b0;
		next_page_addr = flash_page_addr;
		unique case (state)
			BFSG_IDLE: begin
				if (wb_wr && wb_adr_i == `BFSG_REG_CTRL && wb_dat_i[`BFSG_CTRL_EN]) begin
					next_state = BFSG_ARM;
					next_arm_cnt = `BFSG_ARM_CYCLES;
					next_self_write_enable = 1'b1;
					next_cmd_erase = wb_dat_i[`BFSG_CTRL_ERASE];
					next_cmd_write = wb_dat_i[`BFSG_CTRL_WRITE];
					next_lock_set_command = wb_dat_i[`BFSG_CTRL_LOCKSET];
					next_concurrent_area_reenable = wb_dat_i[`BFSG_CTRL_REEN];
				end
			end
			BFSG_ARM: begin
				next_arm_cnt = arm_cnt - 3'h1;
				if (prog_req) begin
					next_state = BFSG_IDLE;
					next_self_write_enable = 1'b0;
					next_cmd_erase = 1'b0;
					next_cmd_write = 1'b0;
					next_lock_set_command = 1'b0;
					next_concurrent_area_reenable = 1'b0;
					if (lock_set_command) begin
						// Bits may only go to programmed, never back
						next_lock_bits = lock_bits & r0_data[3:0];
					end else if (concurrent_area_reenable) begin
						next_busy = 1'b0;
					end else if (cmd_erase || cmd_write) begin
						if (!wr_refused) begin
							// Any page, loader pages too, when unlocked
							next_page_addr = target;
							next_erase_start = cmd_erase;
							next_write_start = cmd_write & ~cmd_erase;
							next_op_halting = tg_halt;
							next_busy = concurrent_area_busy_flag | ~tg_halt;
							next_state = BFSG_BUSY;
							next_op_cnt = 16'(`BFSG_OP_CYCLES);
							next_self_write_enable = 1'b1;
						end
					end else begin
						// Plain buffer load also frees the concurrent area
						next_buf_load = 1'b1;
						next_busy = 1'b0;
					end
				end else if (arm_cnt == 3'h1) begin
					next_state = BFSG_IDLE;
					next_self_write_enable = 1'b0;
					next_cmd_erase = 1'b0;
					next_cmd_write = 1'b0;
					next_lock_set_command = 1'b0;
					next_concurrent_area_reenable = 1'b0;
				end
			end
			BFSG_BUSY: begin
				next_op_cnt = op_cnt - 16'h1;
				if (op_cnt == 16'h1) begin
					next_state = BFSG_IDLE;
					next_self_write_enable = 1'b0;
					next_cmd_erase = 1'b0;
					next_cmd_write = 1'b0;
				end
			end
			default: next_state = BFSG_IDLE;
		endcase
		// Chip erase wins and returns locks to unprogrammed
		if (chip_erase) begin
			next_lock_bits = `BFSG_LOCK_RESET;
		end
	end

	// Next values for CPU-facing gates
	always_comb begin
		next_fuse_q = loader_size_fuses;
		next_load_grant = program_memory_load_op & ~rd_refused;
		next_load_refused = program_memory_load_op & rd_refused;
		// Block is the next busy flag gated by a fetch outside the halting area
		next_fetch_block = fetch_req & ~fe_halt & next_busy;
		// Halting-area operation stalls; concurrent one lets halting fetches run
		next_stall = (next_state == BFSG_BUSY) & next_op_halting;
		next_irq_suppress = (vectors_in_loader & app_rd_lk & ~pc_ldr)
		                  | (~vectors_in_loader & ldr_rd_lk & pc_ldr);
	end

	// Wishbone read and ack; one wait state, unmapped reads give zero
	always_comb begin
		next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		next_dat = 32'h0;
		if (wb_cyc_i && wb_stb_i && !wb_we_i) begin
			unique case (wb_adr_i)
				`BFSG_REG_CTRL: next_dat = {26'h0, concurrent_area_busy_flag,
					concurrent_area_reenable, lock_set_command, cmd_write, cmd_erase,
					self_write_enable};
				`BFSG_REG_LOCK: next_dat = {28'h0, lock_bits};
				`BFSG_REG_STAT: next_dat = {29'h0, state};
				`BFSG_REG_CFG:  next_dat = {30'h0, fuse_q};
				default:        next_dat = 32'h0;
			endcase
		end
	end

	// Register stage
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state <= BFSG_IDLE;
			arm_cnt <= 3'h0;
			op_cnt <= 16'h0;
			self_write_enable <= 1'b0;
			cmd_erase <= 1'b0;
			cmd_write <= 1'b0;
			lock_set_command <= 1'b0;
			concurrent_area_reenable <= 1'b0;
			concurrent_area_busy_flag <= 1'b0;
			op_halting <= 1'b0;
			lock_bits <= `BFSG_LOCK_RESET;
			fuse_q <= 2'h0;
			flash_erase_start <= 1'b0;
			flash_write_start <= 1'b0;
			buf_load <= 1'b0;
			flash_page_addr <= 16'h0;
			load_grant <= 1'b0;
			load_refused <= 1'b0;
			fetch_block <= 1'b0;
			cpu_stall <= 1'b0;
			irq_suppress <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			state <= next_state;
			arm_cnt <= next_arm_cnt;
			op_cnt <= next_op_cnt;
			self_write_enable <= next_self_write_enable;
			cmd_erase <= next_cmd_erase;
			cmd_write <= next_cmd_write;
			lock_set_command <= next_lock_set_command;
			concurrent_area_reenable <= next_concurrent_area_reenable;
			concurrent_area_busy_flag <= next_busy;
			op_halting <= next_op_halting;
			lock_bits <= next_lock_bits;
			fuse_q <= next_fuse_q;
			flash_erase_start <= next_erase_start;
			flash_write_start <= next_write_start;
			buf_load <= next_buf_load;
			flash_page_addr <= next_page_addr;
			load_grant <= next_load_grant;
			load_refused <= next_load_refused;
			fetch_block <= next_fetch_block;
			cpu_stall <= next_stall;
			irq_suppress <= next_irq_suppress;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	// Checks on the sequencer and gates
	AST_APP_IGNORED: assert property (@(posedge clock) disable iff (!rstn)
		flash_self_write_op && !pc_ldr |=> !flash_erase_start && !flash_write_start)
		else $error("self-write from application area started flash");
	AST_LDR_ONLY: assert property (@(posedge clock) disable iff (!rstn)
		flash_erase_start || flash_write_start |-> $past(pc_ldr))
		else $error("flash start without loader execution");
	AST_STALL: assert property (@(posedge clock) disable iff (!rstn)
		state == BFSG_BUSY && op_halting |-> cpu_stall)
		else $error("halting-area operation did not stall");
	AST_NO_STALL: assert property (@(posedge clock) disable iff (!rstn)
		state == BFSG_BUSY && !op_halting |-> !cpu_stall)
		else $error("concurrent-area operation stalled cpu");
	AST_BUSY_BLOCK: assert property (@(posedge clock) disable iff (!rstn)
		fetch_req && !fe_halt && concurrent_area_busy_flag |=> fetch_block)
		else $error("busy concurrent area fetch not blocked");
	AST_ENABLE_HELD: assert property (@(posedge clock) disable iff (!rstn)
		state == BFSG_BUSY |-> self_write_enable)
		else $error("enable dropped during operation");
	AST_LOCK_ONEWAY: assert property (@(posedge clock) disable iff (!rstn)
		!$past(chip_erase) |-> (lock_bits & ~$past(lock_bits)) == 4'h0)
		else $error("lock bit returned without chip erase");
	AST_WR_REFUSED: assert property (@(posedge clock) disable iff (!rstn)
		prog_req && cmd_erase && !lock_set_command && !concurrent_area_reenable
		&& wr_refused |=> !flash_erase_start && $stable(concurrent_area_busy_flag))
		else $error("locked erase went ahead");
	AST_RD_REFUSED: assert property (@(posedge clock) disable iff (!rstn)
		program_memory_load_op && rd_refused |=> load_refused && !load_grant)
		else $error("locked load granted");
	AST_ARM_WINDOW: assert property (@(posedge clock) disable iff (!rstn)
		state == BFSG_ARM && !prog_req |-> ##[1:4] state != BFSG_ARM)
		else $error("arming outlived four cycles");
	AST_LDR_IN_HALT: assert property (@(posedge clock) disable iff (!rstn)
		pc_ldr |-> pc_halt)
		else $error("loader address outside halting area");
	COV_CONC: cover property (@(posedge clock) disable iff (!rstn)
		flash_write_start && !cpu_stall);
	COV_HALT: cover property (@(posedge clock) disable iff (!rstn) cpu_stall);
	COV_LOCKSET: cover property (@(posedge clock) disable iff (!rstn)
		prog_req && lock_set_command);
endmodule // bfsg_guard

/* File: bfsg_guard_tb.sv */
// Self-checking bench for the boot flash section guard
`timescale 1ns/1ps
module bfsg_guard_tb;
	import bfsg_pkg::*;
	// Bench-driven pins
	logic        clock, rstn, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [3:0]  wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i;
	logic        vectors_in_loader, chip_erase;
	logic [1:0]  loader_size_fuses;
	// Partner-driven pins
	bfsg_addr_t  pc, target, fetch_addr;
	logic        flash_self_write_op, program_memory_load_op, fetch_req;
	logic [7:0]  r0_data;
	// Design outputs
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, flash_erase_start, flash_write_start, buf_load;
	bfsg_addr_t  flash_page_addr;
	logic        load_grant, load_refused, fetch_block, cpu_stall, irq_suppress;
	logic [3:0]  lock_bits;
	// Bookkeeping
	int          err_total, samples_checked, n_ers, n_wrt, n_buf;
	logic [31:0] q;

	bfsg_guard dut (
		.clock, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .pc, .target, .flash_self_write_op, .program_memory_load_op,
		.r0_data, .fetch_req, .fetch_addr, .vectors_in_loader, .loader_size_fuses,
		.chip_erase, .flash_erase_start, .flash_write_start, .buf_load, .flash_page_addr,
		.load_grant, .load_refused, .fetch_block, .cpu_stall, .irq_suppress, .lock_bits
	);
	bfsg_cpu_model cpu (
		.clock, .pc, .target, .flash_self_write_op, .program_memory_load_op, .r0_data,
		.fetch_req, .fetch_addr
	);

	// 40 MHz clock
	always #12.5 clock = ~clock;

	// Count start pulses so a late or doubled pulse still shows
	always @(posedge clock) begin
		if (flash_erase_start === 1'b1) n_ers++;
		if (flash_write_start === 1'b1) n_wrt++;
		if (buf_load === 1'b1) n_buf++;
	end

	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_b(input logic got, input logic exp);
		chk_w({31'h0, got}, {31'h0, exp});
	endtask

	// Classic cycle; held until ack is sampled, read data taken at that edge
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	// Arm a command, then issue the self-write inside the window
	task automatic sw(input logic [31:0] c, input bfsg_addr_t p, input bfsg_addr_t t,
			input logic [7:0] r);
		wb(1'b1, 4'h0, c);
		cpu.op(1'b0, p, t, r);
		repeat (3) @(posedge clock);
		#1;
	endtask

	task automatic clr_locks;
		@(posedge clock);
		chip_erase <= 1'b1;
		@(posedge clock);
		chip_erase <= 1'b0;
		@(posedge clock);
		#1;
	endtask

	task automatic t_reset;
		wb(1'b0, 4'h4, 32'h0);
		chk_w(q, 32'hf);
		wb(1'b0, 4'h0, 32'h0);
		chk_w(q, 32'h0);
	endtask

	task automatic t_app_ignored;
		int e;
		e = n_ers;
		sw(32'h3, 16'h0100, 16'h0200, 8'h00);
		chk_w(32'(n_ers - e), 32'h0);
		wb(1'b0, 4'h0, 32'h0);
		chk_b(q[5], 1'b0);
	endtask

	// Program a concurrent-area page, then clear busy with command clr
	task automatic t_conc(input logic [31:0] c, input logic [31:0] clr);
		int e, w, b;
		e = n_ers;
		w = n_wrt;
		b = n_buf;
		sw(c, 16'hf000, 16'h0300, 8'h00);
		chk_w(32'(n_ers - e), {31'h0, c[1]});
		chk_w(32'(n_wrt - w), {31'h0, !c[1]});
		chk_w({16'h0, flash_page_addr}, 32'h0300);
		chk_b(cpu_stall, 1'b0);
		wb(1'b0, 4'h0, 32'h0);
		chk_b(q[0], 1'b1);
		chk_b(q[5], 1'b1);
		cpu.fetch(16'h0100);
		chk_b(fetch_block, 1'b1);
		cpu.fetch(16'he100);
		chk_b(fetch_block, 1'b0);
		do wb(1'b0, 4'h0, 32'h0); while (q[0] === 1'b1);
		chk_b(q[5], 1'b1);
		sw(clr, 16'hf000, 16'h0300, 8'h00);
		wb(1'b0, 4'h0, 32'h0);
		chk_b(q[5], 1'b0);
		chk_w(32'(n_buf - b), {31'h0, !clr[4]});
		cpu.fetch(16'h0100);
		chk_b(fetch_block, 1'b0);
	endtask

	task automatic t_halt;
		int w, n;
		w = n_wrt;
		n = 0;
		sw(32'h5, 16'hf000, 16'hf000, 8'h00);
		chk_w(32'(n_wrt - w), 32'h1);
		chk_b(cpu_stall, 1'b1);
		wb(1'b0, 4'h0, 32'h0);
		chk_b(q[5], 1'b0);
		while (cpu_stall === 1'b1) begin
			@(posedge clock);
			n++;
		end
		chk_b(n > 145 && n < 165, 1'b1);
	endtask

	task automatic t_locks;
		int e;
		sw(32'h9, 16'hf000, 16'h0000, 8'hfe);
		chk_w({28'h0, lock_bits}, 32'he);
		e = n_ers;
		sw(32'h3, 16'hf000, 16'h0100, 8'h00);
		chk_w(32'(n_ers - e), 32'h0);
		wb(1'b0, 4'h0, 32'h0);
		chk_b(q[5], 1'b0);
		sw(32'h9, 16'hf000, 16'h0000, 8'hfb);
		wb(1'b0, 4'h4, 32'h0);
		chk_w(q, 32'ha);
		sw(32'h3, 16'hf000, 16'hf800, 8'h00);
		chk_w(32'(n_ers - e), 32'h0);
		wb(1'b1, 4'h4, 32'hf);
		sw(32'h9, 16'hf000, 16'h0000, 8'hff);
		chk_w({28'h0, lock_bits}, 32'ha);
		wb(1'b1, 4'h0, 32'h9);
		repeat (8) @(posedge clock);
		cpu.op(1'b0, 16'hf000, 16'h0000, 8'h00);
		repeat (2) @(posedge clock);
		#1;
		chk_w({28'h0, lock_bits}, 32'ha);
		clr_locks;
		chk_w({28'h0, lock_bits}, 32'hf);
	endtask

	// Pc and vector placement, then look at the interrupt gate
	task automatic irq_at(input logic v, input bfsg_addr_t p);
		@(posedge clock);
		vectors_in_loader <= v;
		cpu.op(1'b1, p, p, 8'h00);
		@(posedge clock);
		#1;
	endtask

	task automatic t_reads;
		bfsg_addr_t p[4] = '{16'hf000, 16'hf000, 16'h0100, 16'h0100};
		bfsg_addr_t t[4] = '{16'h0100, 16'hf800, 16'hf800, 16'h0200};
		logic ok[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
		sw(32'h9, 16'hf000, 16'h0000, 8'hf5);
		for (int i = 0; i < 4; i++) begin
			cpu.op(1'b1, p[i], t[i], 8'h00);
			chk_b(load_grant, ok[i]);
			chk_b(load_refused, !ok[i]);
		end
		irq_at(1'b1, 16'h0100);
		chk_b(irq_suppress, 1'b1);
		irq_at(1'b0, 16'hf000);
		chk_b(irq_suppress, 1'b1);
		irq_at(1'b1, 16'hf000);
		chk_b(irq_suppress, 1'b0);
		clr_locks;
	endtask

	// Smallest loader leaves the old loader start in the application area
	task automatic t_fuses;
		int e;
		@(posedge clock);
		loader_size_fuses <= 2'h3;
		wb(1'b0, 4'hc, 32'h0);
		chk_w(q, 32'h3);
		e = n_ers;
		sw(32'h3, 16'hf000, 16'h0100, 8'h00);
		chk_w(32'(n_ers - e), 32'h0);
		@(posedge clock);
		loader_size_fuses <= 2'h0;
	endtask

	task automatic tally_and_finish;
		if (err_total == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{clock, rstn, wb_cyc_i, wb_stb_i, wb_we_i, chip_erase} = 6'h0;
		{wb_adr_i, wb_dat_i, loader_size_fuses, vectors_in_loader} = '0;
		wb_sel_i = 4'hf;
		{err_total, samples_checked, n_ers, n_wrt, n_buf} = '0;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		t_reset;
		t_app_ignored;
		t_conc(32'h3, 32'h11);
		t_conc(32'h5, 32'h1);
		t_conc(32'h7, 32'h11);
		t_halt;
		t_locks;
		t_reads;
		t_fuses;
		tally_and_finish;
	end

	// Watchdog, far beyond the fewer than one thousand cycles the tests need
	initial begin
		#500000;
		err_total++;
		tally_and_finish;
	end
endmodule // bfsg_guard_tb

/* File: bfsg_pkg.sv */
// Types for the boot flash section guard
package bfsg_pkg;
	typedef enum logic [2:0] {
		BFSG_IDLE = 3'b001,
		BFSG_ARM  = 3'b010,
		BFSG_BUSY = 3'b100
	} bfsg_state_t;
	typedef logic [15:0] bfsg_addr_t;
endpackage
